// ---- logic/pssp_parser.v ----
// Submessage walker: buffers an incoming message octet stream, checks the
// message header, then decodes each submessage header and the acknack body.
// Assumes one octet per accepted beat, a last marker on the final octet,
// and the transport payload length given with the first octet.
`include "pssp_defines.vh"
`default_nettype none
module pssp_parser #(
    parameter FIFO_DEPTH = 32,
    parameter FIFO_AW    = 5
) (
    // Clock and reset.
    input  wire        core_clk,
    input  wire        reset_n,
    // Incoming message octets.
    input  wire [7:0]  rx_data,
    input  wire        rx_last,
    input  wire        rx_valid,
    output wire        rx_ready,
    input  wire [15:0] rx_msg_len,
    // Decoded submessage header, one pulse per header.
    output reg         sub_valid_r,
    output reg  [7:0]  sub_kind_r,
    output reg  [1:0]  sub_class_r,
    output reg         sub_known_r,
    output reg         sub_little_r,
    output reg  [7:0]  sub_flags_r,
    output reg  [15:0] sub_len_r,
    output reg         sub_last_r,
    output reg  [15:0] msg_vendor_r,
    // Decoded acknack, one pulse per acknack.
    output reg         ack_valid_r,
    output reg  [31:0] ack_reader_r,
    output reg  [31:0] ack_writer_r,
    output reg  [63:0] ack_base_r,
    output reg  [31:0] ack_numbits_r,
    output reg  [31:0] ack_count_r,
    output reg         ack_hb_req_r,
    // Decoded compact IPv4 locator, one pulse.
    output reg         loc_valid_r,
    output reg  [31:0] loc_addr_r,
    output reg  [31:0] loc_port_r,
    // Message status pulses.
    output reg         msg_done_r,
    output reg         msg_error_r
);
    localparam ST_IDLE = 3'h0;
    localparam ST_MHDR = 3'h1;
    localparam ST_SHDR = 3'h2;
    localparam ST_BODY = 3'h3;
    localparam ST_DROP = 3'h4;

    // Classify a kind code into defined, reserved or vendor.
    function [1:0] kind_class;
        input [7:0] k;
        begin
            if (k >= `PSSP_KIND_VEND_MIN)
                kind_class = `PSSP_CLS_VENDOR;
            else if (k >= `PSSP_KIND_SEC_MIN && k <= `PSSP_KIND_SEC_MAX)
                kind_class = `PSSP_CLS_RESERVED;
            else
                kind_class = `PSSP_CLS_DEFINED;
        end
    endfunction

    // True for the kind codes this parser recognises.
    function kind_known;
        input [7:0] k;
        begin
            case (k)
                `PSSP_KIND_PAD, `PSSP_KIND_ACKNACK, `PSSP_KIND_HEARTBEAT,
                `PSSP_KIND_GAP, `PSSP_KIND_INFO_TS, `PSSP_KIND_INFO_SRC,
                `PSSP_KIND_REPLY_IP4, `PSSP_KIND_INFO_DST,
                `PSSP_KIND_INFO_REPLY, `PSSP_KIND_NACK_FRAG,
                `PSSP_KIND_HB_FRAG, `PSSP_KIND_DATA, `PSSP_KIND_DATA_FRAG:
                    kind_known = 1'b1;
                default:
                    kind_known = 1'b0;
            endcase
        end
    endfunction

    // Merge one octet into a 32-bit field at lane i, in either byte order.
    function [31:0] put8;
        input [31:0] w;
        input [7:0]  b;
        input [1:0]  i;
        input        le;
        reg   [1:0]  lane;
        begin
            lane = le ? i : (2'h3 - i);
            put8 = w;
            put8[lane*8 +: 8] = b;
        end
    endfunction

    wire [7:0] f_data;
    wire       f_last;
    wire       f_valid;
    wire       f_ready;
    reg        len_take_r;

    pssp_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .core_clk  (core_clk),
        .reset_n   (reset_n),
        .in_data   ({rx_last, rx_data}),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .out_data  ({f_last, f_data}),
        .out_valid (f_valid),
        .out_ready (f_ready)
    );

    reg [2:0]  st_r;
    reg [15:0] pos_r;
    reg [15:0] rem_r;
    reg [15:0] msg_len_r;
    reg [15:0] body_r;
    reg [7:0]  kind_r;
    reg [7:0]  flags_r;
    reg [7:0]  len_lo_r;
    reg        ver_ok_r;
    reg [15:0] pend_len_r;

    // Octets only drain once the message length has been captured.
    assign f_ready = (st_r != ST_IDLE) || len_take_r;

    wire        beat   = f_valid && f_ready;
    wire [1:0]  lane   = pos_r[1:0];
    wire        le     = flags_r[`PSSP_FLAG_E_BIT];
    wire [15:0] raw_len = le ? {f_data, len_lo_r} : {len_lo_r, f_data};
    wire [15:0] room   = rem_r - 16'h0001;
    wire        is_pad = (kind_r == `PSSP_KIND_PAD) ||
                         (kind_r == `PSSP_KIND_INFO_TS);

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r          <= ST_IDLE;
            pos_r         <= 16'h0000;
            rem_r         <= 16'h0000;
            msg_len_r     <= 16'h0000;
            body_r        <= 16'h0000;
            kind_r        <= 8'h00;
            flags_r       <= 8'h00;
            len_lo_r      <= 8'h00;
            ver_ok_r      <= 1'b0;
            pend_len_r    <= 16'h0000;
            len_take_r    <= 1'b0;
            sub_valid_r   <= 1'b0;
            sub_kind_r    <= 8'h00;
            sub_class_r   <= 2'h0;
            sub_known_r   <= 1'b0;
            sub_little_r  <= 1'b0;
            sub_flags_r   <= 8'h00;
            sub_len_r     <= 16'h0000;
            sub_last_r    <= 1'b0;
            msg_vendor_r  <= 16'h0000;
            ack_valid_r   <= 1'b0;
            ack_reader_r  <= 32'h0;
            ack_writer_r  <= 32'h0;
            ack_base_r    <= 64'h0;
            ack_numbits_r <= 32'h0;
            ack_count_r   <= 32'h0;
            ack_hb_req_r  <= 1'b0;
            loc_valid_r   <= 1'b0;
            loc_addr_r    <= 32'h0;
            loc_port_r    <= 32'h0;
            msg_done_r    <= 1'b0;
            msg_error_r   <= 1'b0;
        end else begin
            sub_valid_r <= 1'b0;
            ack_valid_r <= 1'b0;
            loc_valid_r <= 1'b0;
            msg_done_r  <= 1'b0;
            msg_error_r <= 1'b0;
            len_take_r  <= 1'b0;
            case (st_r)
            ST_IDLE: begin
                if (f_valid && !len_take_r) begin
                    msg_len_r  <= rx_msg_len;
                    rem_r      <= rx_msg_len;
                    pos_r      <= 16'h0000;
                    ver_ok_r   <= 1'b1;
                    len_take_r <= 1'b1;
                    st_r       <= ST_MHDR;
                end
            end
            ST_MHDR: if (beat) begin
                rem_r <= room;
                pos_r <= pos_r + 16'h0001;
                // Vendor id is two octets, always most significant first.
                if (pos_r == `PSSP_MSG_MAJOR_OFS &&
                    f_data != `PSSP_MAJOR_VER)
                    ver_ok_r <= 1'b0;
                if (pos_r == `PSSP_MSG_VID_OFS)
                    msg_vendor_r[15:8] <= f_data;
                if (pos_r == `PSSP_MSG_VID_OFS + 16'h0001)
                    msg_vendor_r[7:0] <= f_data;
                if (f_last || pos_r == `PSSP_MSG_HDR_LEN - 16'h0001) begin
                    pos_r <= 16'h0000;
                    if (!ver_ok_r || f_last ||
                        msg_len_r < `PSSP_MSG_HDR_LEN) begin
                        msg_error_r <= 1'b1;
                        st_r <= f_last ? ST_IDLE : ST_DROP;
                    end else if (room == 16'h0000) begin
                        msg_done_r <= 1'b1;
                        st_r <= ST_IDLE;
                    end else
                        st_r <= ST_SHDR;
                end
            end
            ST_SHDR: if (beat) begin
                rem_r <= room;
                pos_r <= pos_r + 16'h0001;
                case (lane)
                2'h0: kind_r   <= f_data;
                2'h1: flags_r  <= f_data;
                2'h2: len_lo_r <= f_data;
                default: begin
                    sub_valid_r  <= 1'b1;
                    sub_kind_r   <= kind_r;
                    sub_class_r  <= kind_known(kind_r) ? kind_class(kind_r)
                                  : (kind_class(kind_r) ==
                                     `PSSP_CLS_DEFINED ?
                                     `PSSP_CLS_UNKNOWN : kind_class(kind_r));
                    sub_known_r  <= kind_known(kind_r);
                    sub_little_r <= le;
                    sub_flags_r  <= flags_r;
                    sub_len_r    <= raw_len;
                    pos_r        <= 16'h0000;
                    ack_hb_req_r <= 1'b0;
                    if (raw_len == 16'h0000 && !is_pad) begin
                        body_r     <= room;
                        sub_last_r <= 1'b1;
                    end else begin
                        body_r     <= raw_len;
                        sub_last_r <= (raw_len == room);
                    end
                    if (raw_len > room) begin
                        msg_error_r <= 1'b1;
                        st_r <= f_last ? ST_IDLE : ST_DROP;
                    end else if (room == 16'h0000 || f_last) begin
                        msg_done_r <= 1'b1;
                        st_r <= f_last ? ST_IDLE : ST_DROP;
                    end else if (raw_len == 16'h0000 && is_pad)
                        st_r <= ST_SHDR;
                    else
                        st_r <= ST_BODY;
                end
                endcase
                if (f_last && lane != 2'h3) begin
                    msg_error_r <= 1'b1;
                    st_r <= ST_IDLE;
                end
            end
            ST_BODY: if (beat) begin
                rem_r  <= room;
                body_r <= body_r - 16'h0001;
                pos_r  <= pos_r + 16'h0001;
                // Flag bits other than E and F are never looked at.
                if (kind_r == `PSSP_KIND_ACKNACK) begin
                    if (pos_r < `PSSP_ACK_WRT_OFS)
                        ack_reader_r <= put8(ack_reader_r, f_data, lane, 1'b0);
                    else if (pos_r < `PSSP_ACK_SNB_OFS)
                        ack_writer_r <= put8(ack_writer_r, f_data, lane, 1'b0);
                    else if (pos_r < `PSSP_ACK_SNB_OFS + 16'h0004)
                        ack_base_r[63:32] <= put8(ack_base_r[63:32], f_data,
                                                  lane, le);
                    else if (pos_r < `PSSP_ACK_NUMB_OFS)
                        ack_base_r[31:0] <= put8(ack_base_r[31:0], f_data,
                                                 lane, le);
                    else if (pos_r < `PSSP_ACK_BMAP_OFS)
                        ack_numbits_r <= put8(ack_numbits_r, f_data, lane, le);
                    ack_count_r <= put8(ack_count_r, f_data, lane, le);
                end
                if (kind_r == `PSSP_KIND_REPLY_IP4 &&
                    pos_r < `PSSP_LOC4_LEN) begin
                    if (pos_r < 16'h0004)
                        loc_addr_r <= put8(loc_addr_r, f_data, lane, le);
                    else
                        loc_port_r <= put8(loc_port_r, f_data, lane, le);
                    if (pos_r == `PSSP_LOC4_LEN - 16'h0001)
                        loc_valid_r <= 1'b1;
                end
                if (body_r == 16'h0001 || f_last) begin
                    pos_r <= 16'h0000;
                    if (kind_r == `PSSP_KIND_ACKNACK) begin
                        ack_valid_r  <= 1'b1;
                        ack_hb_req_r <= !flags_r[`PSSP_FLAG_F_BIT];
                    end
                    if (f_last || room == 16'h0000) begin
                        msg_done_r <= 1'b1;
                        st_r <= f_last ? ST_IDLE : ST_DROP;
                    end else
                        st_r <= ST_SHDR;
                end
            end
            ST_DROP: if (beat && f_last)
                st_r <= ST_IDLE;
            default: st_r <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- logic/pssp_defines.vh ----
// Constants for the submessage parser: header layout, kind codes, ranges.
// Assumes inclusion by bare name from design files.
`ifndef PSSP_DEFINES_VH
`define PSSP_DEFINES_VH
`define PSSP_MSG_HDR_LEN     16'h0014
`define PSSP_MSG_VID_OFS     16'h0006
`define PSSP_MSG_MAJOR_OFS   16'h0004
`define PSSP_MAJOR_VER       8'h02
`define PSSP_SUB_HDR_LEN     16'h0004
`define PSSP_FLAG_E_BIT      0
`define PSSP_FLAG_F_BIT      1
`define PSSP_KIND_VEND_MIN   8'h80
`define PSSP_KIND_SEC_MIN    8'h30
`define PSSP_KIND_SEC_MAX    8'h3F
`define PSSP_KIND_PAD        8'h01
`define PSSP_KIND_ACKNACK    8'h06
`define PSSP_KIND_HEARTBEAT  8'h07
`define PSSP_KIND_GAP        8'h08
`define PSSP_KIND_INFO_TS    8'h09
`define PSSP_KIND_INFO_SRC   8'h0C
`define PSSP_KIND_REPLY_IP4  8'h0D
`define PSSP_KIND_INFO_DST   8'h0E
`define PSSP_KIND_INFO_REPLY 8'h0F
`define PSSP_KIND_NACK_FRAG  8'h12
`define PSSP_KIND_HB_FRAG    8'h13
`define PSSP_KIND_DATA       8'h15
`define PSSP_KIND_DATA_FRAG  8'h16
`define PSSP_CLS_DEFINED     2'h0
`define PSSP_CLS_RESERVED    2'h1
`define PSSP_CLS_VENDOR      2'h2
`define PSSP_CLS_UNKNOWN     2'h3
`define PSSP_ACK_RDR_OFS     16'h0000
`define PSSP_ACK_WRT_OFS     16'h0004
`define PSSP_ACK_SNB_OFS     16'h0008
`define PSSP_ACK_NUMB_OFS    16'h0010
`define PSSP_ACK_BMAP_OFS    16'h0014
`define PSSP_LOC4_LEN        16'h0008
`endif

// ---- logic/pssp_fifo.v ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`default_nettype none
module pssp_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset.
    input  wire             core_clk,
    input  wire             reset_n,
    // Fill side.
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    // Drain side.
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_r;
    reg [AW:0]      rd_r;
    wire            full  = (wr_r[AW] != rd_r[AW]) &&
                            (wr_r[AW-1:0] == rd_r[AW-1:0]);
    wire            empty = (wr_r == rd_r);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_r[AW-1:0]];
    always @(posedge core_clk) begin
        if (in_valid && !full)
            mem[wr_r[AW-1:0]] <= in_data;
    end
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_r <= {(AW+1){1'b0}};
            rd_r <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full)
                wr_r <= wr_r + 1'b1;
            if (out_ready && !empty)
                rd_r <= rd_r + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- dv/pssp_sender.sv ----
// Sender model: offers queued message octets on the valid/ready port.
// Assumes the bench queues lengths before octets, at falling edges.
`default_nettype none
module pssp_sender (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    // Pace control: an idle cycle after each accepted octet.
    input  wire logic        slow,
    // Octet stream towards the parser.
    output logic [7:0]       rx_data,
    output logic             rx_last,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    output logic [15:0]      rx_msg_len
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [8:0]  oq[$];
    logic [15:0] lq[$];
    logic        took;
    initial begin
        {rx_data, rx_last, rx_valid, rx_msg_len, took} = '0;
    end
    always @(posedge core_clk) begin
        took <= rx_valid && rx_ready;
    end
    always @(negedge core_clk) begin
        if (took) begin
            if (oq[0][8]) void'(lq.pop_front());
            void'(oq.pop_front());
        end
        if (lq.size() != 0) rx_msg_len = lq[0];
        if (reset_n && oq.size() != 0 && !(slow && took)) begin
            {rx_last, rx_data} = oq[0];
            rx_valid = 1'b1;
        end else begin
            // A released line changes every cycle so stale data never passes.
            rx_valid = 1'b0;
            rx_last = 1'b0;
            rx_data = ~rx_data;
        end
    end
endmodule
`default_nettype wire

// ---- dv/pssp_parser_monitor.sv ----
// Checker for the decoded submessage header and status pulses.
// Assumes it is bound to pssp_parser and sees only its ports.
`default_nettype none
module pssp_parser_monitor (
    // Clock and reset.
    input wire logic        core_clk,
    input wire logic        reset_n,
    // Decoded header, acknack and status.
    input wire logic        sub_valid_r,
    input wire logic [7:0]  sub_kind_r,
    input wire logic [1:0]  sub_class_r,
    input wire logic        sub_known_r,
    input wire logic        sub_little_r,
    input wire logic [7:0]  sub_flags_r,
    input wire logic [15:0] sub_len_r,
    input wire logic        sub_last_r,
    input wire logic        ack_valid_r,
    input wire logic        ack_hb_req_r,
    input wire logic        msg_done_r,
    input wire logic        msg_error_r
);
    timeunit 1ns;
    timeprecision 100ps;
    logic in_sec;
    logic known;
    assign in_sec = sub_kind_r >= 8'h30 && sub_kind_r <= 8'h3F;
    assign known = sub_kind_r inside {8'h01, 8'h06, 8'h07, 8'h08, 8'h09,
        8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h12, 8'h13, 8'h15, 8'h16};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_vendor_class: assert property (
        sub_valid_r && sub_kind_r >= 8'h80 |-> sub_class_r == 2'h2)
        else $error("vendor kind misclassed");
    a_reserved_class: assert property (
        sub_valid_r && in_sec |-> sub_class_r == 2'h1)
        else $error("reserved kind misclassed");
    a_defined_class: assert property (
        sub_valid_r && sub_kind_r < 8'h80 && !in_sec
        |-> sub_class_r == (known ? 2'h0 : 2'h3))
        else $error("defined kind misclassed");
    a_known_codes: assert property (
        sub_valid_r |-> sub_known_r == known)
        else $error("known flag wrong");
    a_order_flag: assert property (
        sub_valid_r |-> sub_little_r == sub_flags_r[0])
        else $error("byte order flag wrong");
    a_zero_last: assert property (
        sub_valid_r && sub_len_r == 16'h0000 && sub_kind_r != 8'h01
        && sub_kind_r != 8'h09 |-> sub_last_r)
        else $error("zero length not last");
    a_final_flag: assert property (
        ack_valid_r && !sub_valid_r |-> ack_hb_req_r == !sub_flags_r[1])
        else $error("heartbeat request wrong");
    a_header_gap: assert property (
        sub_valid_r |=> !sub_valid_r [*3])
        else $error("headers closer than four octets");
    a_status_excl: assert property (
        !(msg_done_r && msg_error_r))
        else $error("done and error together");
endmodule
bind pssp_parser pssp_parser_monitor i_mon (.core_clk, .reset_n,
    .sub_valid_r, .sub_kind_r, .sub_class_r, .sub_known_r, .sub_little_r,
    .sub_flags_r, .sub_len_r, .sub_last_r, .ack_valid_r, .ack_hb_req_r,
    .msg_done_r, .msg_error_r);
`default_nettype wire

// ---- dv/test_pssp_parser.sv ----
// Testbench for the submessage parser, fed by the sender model.
// Assumes a 100 MHz clock and whole messages ending with a last marker.
`default_nettype none
module test_pssp_parser;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] VENDOR = 16'h5A3C; // Arbitrary vendor code.
    logic         core_clk, reset_n, slow, rx_last, rx_valid, rx_ready;
    logic [7:0]   rx_data, sub_kind_r, sub_flags_r;
    logic         sub_valid_r, sub_known_r, sub_little_r, sub_last_r;
    logic [1:0]   sub_class_r;
    logic [15:0]  rx_msg_len, sub_len_r, msg_vendor_r;
    logic         ack_valid_r, ack_hb_req_r, loc_valid_r;
    logic         msg_done_r, msg_error_r;
    logic [31:0]  ack_reader_r, ack_writer_r, ack_numbits_r, ack_count_r;
    logic [31:0]  loc_addr_r, loc_port_r;
    logic [63:0]  ack_base_r;
    logic [7:0]   mq[$];
    logic [28:0]  sq[$], eq[$];
    logic [192:0] aq[$];
    int           fail_count, total_checks, done_cnt, err_cnt, loc_cnt;
    pssp_sender i_src (.core_clk, .reset_n, .slow, .rx_data, .rx_last,
        .rx_valid, .rx_ready, .rx_msg_len);
    pssp_parser i_dut (.core_clk, .reset_n, .rx_data, .rx_last, .rx_valid,
        .rx_ready, .rx_msg_len, .sub_valid_r, .sub_kind_r, .sub_class_r,
        .sub_known_r, .sub_little_r, .sub_flags_r, .sub_len_r, .sub_last_r,
        .msg_vendor_r, .ack_valid_r, .ack_reader_r, .ack_writer_r,
        .ack_base_r, .ack_numbits_r, .ack_count_r, .ack_hb_req_r,
        .loc_valid_r, .loc_addr_r, .loc_port_r, .msg_done_r, .msg_error_r);
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (sub_valid_r) sq.push_back({sub_known_r, sub_class_r,
            sub_little_r, sub_last_r, sub_len_r, sub_kind_r});
        if (ack_valid_r) aq.push_back({ack_hb_req_r, ack_count_r,
            ack_numbits_r, ack_base_r, ack_writer_r, ack_reader_r});
        done_cnt += msg_done_r;
        err_cnt += msg_error_r;
        loc_cnt += loc_valid_r;
    end
    function automatic logic known(input logic [7:0] k);
        return k inside {8'h01, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0C, 8'h0D,
            8'h0E, 8'h0F, 8'h12, 8'h13, 8'h15, 8'h16};
    endfunction
    function automatic logic [1:0] cls(input logic [7:0] k);
        if (k >= 8'h80) return 2'h2;
        if (k >= 8'h30 && k <= 8'h3F) return 2'h1;
        return known(k) ? 2'h0 : 2'h3;
    endfunction
    task automatic check(input logic [199:0] got, input logic [199:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic start();
        {done_cnt, err_cnt, loc_cnt} = '0;
        sq = {};
        eq = {};
        aq = {};
    endtask
    task automatic put4(input logic [31:0] w, input logic le);
        for (int i = 0; i < 4; i++)
            mq.push_back(le ? w[8*i+:8] : w[31-8*i-:8]);
    endtask
    task automatic hdr(input logic [7:0] ver, input logic [7:0] minor);
        mq = {};
        put4(32'h50535350, 1'b0);
        mq.push_back(ver);
        mq.push_back(minor);
        mq.push_back(VENDOR[15:8]);
        mq.push_back(VENDOR[7:0]);
        repeat (3) put4(32'hC0DE0000 + 32'(mq.size()), 1'b0);
    endtask
    task automatic sub(input logic [7:0] k, input logic [7:0] f,
                       input logic [15:0] n, input logic last);
        mq.push_back(k);
        mq.push_back(f);
        mq.push_back(f[0] ? n[7:0] : n[15:8]);
        mq.push_back(f[0] ? n[15:8] : n[7:0]);
        eq.push_back({known(k), cls(k), f[0], last, n, k});
    endtask
    task automatic fill(input int n);
        repeat (n) mq.push_back(8'hA5 ^ 8'(mq.size()));
    endtask
    task automatic push_msg();
        i_src.lq.push_back(16'(mq.size()));
        foreach (mq[i]) i_src.oq.push_back({i == mq.size() - 1, mq[i]});
    endtask
    task automatic wait_end(input int n);
        int t;
        t = 0;
        while (done_cnt + err_cnt < n && t < 3000) begin
            @(negedge core_clk);
            t++;
        end
        repeat (3) @(negedge core_clk);
        check(32'(t < 3000), 32'd1);
        check(32'(sq.size()), 32'(eq.size()));
        foreach (eq[i]) if (i < sq.size()) check(sq[i], eq[i]);
    endtask
    task automatic t_kinds();
        logic [7:0] ks[19] = '{8'h01, 8'h07, 8'h08, 8'h09, 8'h0C, 8'h0D,
            8'h0E, 8'h0F, 8'h12, 8'h13, 8'h15, 8'h16, 8'h02, 8'h7F, 8'h30,
            8'h3F, 8'h80, 8'hC5, 8'hFF};
        start();
        hdr(8'h02, 8'h01);
        foreach (ks[i]) begin
            sub(ks[i], 8'(i % 2) | (i % 3 == 0 ? 8'hE0 : 8'h00), 16'h0008,
                i == 18);
            fill(8);
        end
        push_msg();
        hdr(8'h02, 8'h07);
        sub(8'h15, 8'h00, 16'h0000, 1'b1);
        fill(5);
        push_msg();
        wait_end(2);
        check(32'(done_cnt), 32'd2);
        check(32'(loc_cnt), 32'd1);
        check(msg_vendor_r, VENDOR);
        $display("t_kinds finished");
    endtask
    task automatic t_zero();
        start();
        hdr(8'h02, 8'h04);
        sub(8'h01, 8'h00, 16'h0000, 1'b0);
        sub(8'h09, 8'h01, 16'h0000, 1'b0);
        sub(8'h0D, 8'h00, 16'h0008, 1'b0);
        put4(32'hC0A80A01, 1'b0);
        put4(32'h00001F90, 1'b0);
        sub(8'h15, 8'h00, 16'h0000, 1'b1);
        fill(40);
        push_msg();
        wait_end(1);
        check(32'(done_cnt), 32'd1);
        check(loc_addr_r, 32'hC0A80A01);
        check(loc_port_r, 32'h00001F90);
        $display("t_zero finished");
    endtask
    task automatic t_ack();
        logic [31:0] sn[4] = '{32'h1, 32'h2, 32'd32, 32'hF0000000};
        start();
        slow = 1'b1;
        hdr(8'h02, 8'h04);
        for (int j = 0; j < 2; j++) begin
            sub(8'h06, j ? 8'h02 : 8'h01, 16'h001C, j == 1);
            put4(32'h11223344, 1'b0);
            put4(32'h55667788, 1'b0);
            foreach (sn[k])
                put4(sn[k], j == 0);
            put4(32'd7 + 32'(j), j == 0);
        end
        push_msg();
        wait_end(1);
        slow = 1'b0;
        check(32'(aq.size()), 32'd2);
        for (int j = 0; j < 2; j++)
            check(aq[j], {j == 0, 32'd7 + 32'(j), 32'd32,
                64'h0000000100000002, 32'h55667788, 32'h11223344});
        $display("t_ack finished");
    endtask
    task automatic t_error();
        start();
        hdr(8'h02, 8'h04);
        sub(8'h15, 8'h00, 16'h0040, 1'b0);
        fill(8);
        push_msg();
        hdr(8'h03, 8'h00);
        fill(8);
        push_msg();
        wait_end(2);
        check(32'(err_cnt), 32'd2);
        check(32'(done_cnt), 32'd0);
        $display("t_error finished");
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #200us;
        fail_count++;
        report_and_stop();
    end
    initial begin
        {fail_count, total_checks, reset_n, slow} = '0;
        repeat (2) @(negedge core_clk);
        reset_n = 1'b1;
        t_kinds();
        t_zero();
        t_ack();
        t_error();
        report_and_stop();
    end
endmodule
`default_nettype wire
